// ==== src/dpll_ref_monitor_config.v ====
// Purpose: configuration bank and alarm gating for the reference
//          frequency monitors and the loop capture range
// Assumes: offsets arrive as |offset| in 0.1 ppm with a sample strobe
// Notes:   registers reached on the serial port's byte access strobes
`include "dpll_ref_monitor_config_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module dpll_ref_monitor_config (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // register access from the serial port
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg         reg_hit,
  // frequency offsets per reference, 13 bits each, ref0 lowest
  input  wire        offset_valid,
  input  wire [51:0] ref_offset,
  // loop offset against the capture range
  input  wire [12:0] loop_offset,
  output reg         loop_in_range,
  output wire [2:0]  capture_range_code,
  // verdicts and alarms
  output wire [3:0]  ref_failed,
  output reg  [3:0]  ref_alarm,
  output reg  [3:0]  ref_switch_req,
  output reg  [3:0]  holdover_req
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [7:0] loop_capture_range_ff;
  reg  [7:0] alarm_action_masks_ff;
  reg  [7:0] ref_alarm_masks_ff;
  reg  [7:0] ref23_monitor_windows_ff;
  reg  [7:0] ref01_monitor_windows_ff;
  reg  [3:0] verdict_fail_ff;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_capture_range_ff    <= `RST_LOOP_CAPTURE_RANGE;
      alarm_action_masks_ff    <= `RST_ALARM_ACTION_MASKS;
      ref_alarm_masks_ff       <= `RST_REF_ALARM_MASKS;
      ref23_monitor_windows_ff <= `RST_MONITOR_WINDOWS;
      ref01_monitor_windows_ff <= `RST_MONITOR_WINDOWS;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_LOOP_CAPTURE_RANGE:    loop_capture_range_ff    <= reg_wdata;
        `OFS_ALARM_ACTION_MASKS:    alarm_action_masks_ff    <= reg_wdata;
        `OFS_REF_ALARM_MASKS:       ref_alarm_masks_ff       <= reg_wdata;
        `OFS_REF23_MONITOR_WINDOWS: ref23_monitor_windows_ff <= reg_wdata;
        `OFS_REF01_MONITOR_WINDOWS: ref01_monitor_windows_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // read-back
  // ----------------------------------------
  always @* begin
    reg_hit   = 1'b1;
    reg_rdata = 8'h00;
    case (reg_addr)
      `OFS_LOOP_CAPTURE_RANGE:    reg_rdata = loop_capture_range_ff;
      `OFS_ALARM_ACTION_MASKS:    reg_rdata = alarm_action_masks_ff;
      `OFS_REF_ALARM_MASKS:       reg_rdata = ref_alarm_masks_ff;
      `OFS_REF23_MONITOR_WINDOWS: reg_rdata = ref23_monitor_windows_ff;
      `OFS_REF01_MONITOR_WINDOWS: reg_rdata = ref01_monitor_windows_ff;
      default:                    reg_hit   = 1'b0;
    endcase
  end

  // ----------------------------------------
  // capture range
  // ----------------------------------------
  assign capture_range_code = loop_capture_range_ff[2:0];

  reg [12:0] cap_limit;
  always @* begin
    case (capture_range_code)
      `CAP_12PPM:     cap_limit = `CAPLIM_12;
      `CAP_52PPM:     cap_limit = `CAPLIM_52;
      `CAP_83PPM:     cap_limit = `CAPLIM_83;
      `CAP_130PPM:    cap_limit = `CAPLIM_130;
      `CAP_400PPM:    cap_limit = `CAPLIM_400;
      default:        cap_limit = `CAPLIM_NONE;
    endcase
  end

  always @* begin
    if (capture_range_code == `CAP_UNLIMITED)
      loop_in_range = 1'b1;
    else
      loop_in_range = (loop_offset <= cap_limit);
  end

  // ----------------------------------------
  // window decode per reference
  // ----------------------------------------
  wire [11:0] win_codes = {ref23_monitor_windows_ff[`ODD_WINDOW_LSB +: 3],
                           ref23_monitor_windows_ff[`EVEN_WINDOW_LSB +: 3],
                           ref01_monitor_windows_ff[`ODD_WINDOW_LSB +: 3],
                           ref01_monitor_windows_ff[`EVEN_WINDOW_LSB +: 3]};

  function [25:0] win_limits;
    input [2:0] code;
    begin
      case (code)
        3'h0:    win_limits = {`ACC_0, `REJ_0};
        3'h1:    win_limits = {`ACC_1, `REJ_1};
        3'h2:    win_limits = {`ACC_2, `REJ_2};
        3'h3:    win_limits = {`ACC_3, `REJ_3};
        3'h4:    win_limits = {`ACC_4, `REJ_4};
        3'h5:    win_limits = {`ACC_5, `REJ_5};
        3'h6:    win_limits = {`ACC_6, `REJ_6};
        default: win_limits = {`ACC_7, `REJ_7};
      endcase
    end
  endfunction

  // ----------------------------------------
  // hysteresis verdicts
  // ----------------------------------------
  reg [3:0] nxt_verdict_fail;
  reg [25:0] lim;
  reg [12:0] off;
  integer i;
  always @* begin
    nxt_verdict_fail = verdict_fail_ff;
    lim = 26'h0;
    off = 13'h0;
    for (i = 0; i < 4; i = i + 1) begin
      lim = win_limits(win_codes[3*i +: 3]);
      off = ref_offset[13*i +: 13];
      if (offset_valid) begin
        if (off <= lim[25:13])
          nxt_verdict_fail[i] = 1'b0;
        else if (off > lim[12:0])
          nxt_verdict_fail[i] = 1'b1;
      end
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      verdict_fail_ff <= 4'h0;
    else
      verdict_fail_ff <= nxt_verdict_fail;
  end

  assign ref_failed = verdict_fail_ff;

  // ----------------------------------------
  // alarm gating
  // ----------------------------------------
  always @* begin
    ref_alarm      = verdict_fail_ff & ref_alarm_masks_ff[3:0];
    ref_switch_req = ref_alarm & {4{alarm_action_masks_ff[`BIT_SWITCH_MASK]}};
    holdover_req   = ref_alarm & {4{alarm_action_masks_ff[`BIT_HOLDOVER_MASK]}};
  end

endmodule

`default_nettype wire

// ==== src/dpll_ref_monitor_config_regs.vh ====
// Purpose: offsets, field positions, reset values and window limits for
//          the reference monitor configuration bank
// Assumes: 8-bit registers on an 8-bit address, limits in units of 0.1 ppm
// Notes:   included by the bank and by the testbench
`ifndef DPLL_REF_MONITOR_CONFIG_REGS_VH
`define DPLL_REF_MONITOR_CONFIG_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_LOOP_CAPTURE_RANGE    8'hed
`define OFS_ALARM_ACTION_MASKS    8'hf4
`define OFS_REF_ALARM_MASKS       8'hf5
`define OFS_REF23_MONITOR_WINDOWS 8'hf6
`define OFS_REF01_MONITOR_WINDOWS 8'hf7

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_LOOP_CAPTURE_RANGE    8'h07
`define RST_ALARM_ACTION_MASKS    8'hf0
`define RST_REF_ALARM_MASKS       8'h00
`define RST_MONITOR_WINDOWS       8'h33

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_SWITCH_MASK           0
`define BIT_HOLDOVER_MASK         4
`define EVEN_WINDOW_LSB           0
`define ODD_WINDOW_LSB            4

// ----------------------------------------
// capture range codes
// ----------------------------------------
`define CAP_12PPM                 3'h0
`define CAP_52PPM                 3'h1
`define CAP_83PPM                 3'h2
`define CAP_130PPM                3'h3
`define CAP_400PPM                3'h4
`define CAP_UNLIMITED             3'h7

// ----------------------------------------
// limits in 0.1 ppm
// ----------------------------------------
`define PPM_W                     13
`define CAPLIM_12                 13'h0078
`define CAPLIM_52                 13'h0208
`define CAPLIM_83                 13'h033e
`define CAPLIM_130                13'h0514
`define CAPLIM_400                13'h0fa0
`define CAPLIM_NONE               13'h1fff
`define ACC_0                     13'h005c
`define REJ_0                     13'h0078
`define ACC_1                     13'h0190
`define REJ_1                     13'h0208
`define ACC_2                     13'h0280
`define REJ_2                     13'h033e
`define ACC_3                     13'h03e8
`define REJ_3                     13'h0514
`define ACC_4                     13'h008a
`define REJ_4                     13'h00b4
`define ACC_5                     13'h00f6
`define REJ_5                     13'h0140
`define ACC_6                     13'h0150
`define REJ_6                     13'h01db
`define ACC_7                     13'h0208
`define REJ_7                     13'h02a3

`endif

// ==== tb/ref_cfg_monitor.sv ====
// Purpose: port checks for the reference monitor configuration bank
// Assumes: mask shadows follow the byte writes seen at the ports
// Notes:   bound to the bank below
`timescale 1ns/1ps
`default_nettype none
module ref_cfg_monitor (
  // clock, reset, register port
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_hit,
  // sample strobe and monitor outputs
  input wire logic       offset_valid,
  input wire logic       loop_in_range,
  input wire logic [2:0] capture_range_code,
  input wire logic [3:0] ref_failed,
  input wire logic [3:0] ref_alarm,
  input wire logic [3:0] ref_switch_req,
  input wire logic [3:0] holdover_req
);
  logic [7:0] msk_ff;
  logic [7:0] act_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      msk_ff <= 8'h00;
      act_ff <= 8'hf0;
    end else if (reg_wr && reg_addr == 8'hf5) begin
      msk_ff <= reg_wdata;
    end else if (reg_wr && reg_addr == 8'hf4) begin
      act_ff <= reg_wdata;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_s; reg_wr && reg_hit; endsequence
  sequence same_s; !reg_wr && reg_addr == $past(reg_addr); endsequence
  AST_WRITE: assert property (wr_s ##1 same_s |-> reg_rdata == $past(reg_wdata))
    else $error("read back differs from written byte");
  AST_HIT: assert property (reg_hit == (reg_addr inside {8'hed, 8'hf4, 8'hf5, 8'hf6, 8'hf7}))
    else $error("address decode wrong");
  AST_UNMAPPED: assert property (!reg_hit |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_ALARM: assert property (ref_alarm == (ref_failed & msk_ff[3:0]))
    else $error("alarm gating wrong");
  AST_SWITCH: assert property (ref_switch_req == (ref_alarm & {4{act_ff[0]}}))
    else $error("switch request gating wrong");
  AST_HOLDOVER: assert property (holdover_req == (ref_alarm & {4{act_ff[4]}}))
    else $error("holdover request gating wrong");
  AST_VERDICT_HOLD: assert property (!offset_valid |=> $stable(ref_failed))
    else $error("verdict moved without a sample");
  AST_UNLIMITED: assert property (capture_range_code == 3'h7 |-> loop_in_range)
    else $error("unlimited range not in range");
endmodule
bind dpll_ref_monitor_config ref_cfg_monitor ref_cfg_monitor_inst (.core_clk, .rst_n, .reg_wr,
  .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .offset_valid, .loop_in_range,
  .capture_range_code, .ref_failed, .ref_alarm, .ref_switch_req, .holdover_req);
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the reference monitor configuration bank
// Assumes: offsets and limits in 0.1 ppm
// Notes:   driver queues expectations, watcher compares them
`timescale 1ns/1ps
`default_nettype none
`include "dpll_ref_monitor_config_regs.vh"
module testbench;
  logic        core_clk, rst_n, reg_wr, reg_rd, offset_valid, reg_hit, loop_in_range;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, seen, rnd;
  logic [51:0] ref_offset;
  logic [12:0] loop_offset;
  logic [2:0]  capture_range_code, w;
  logic [3:0]  ref_failed, ref_alarm, ref_switch_req, holdover_req;
  logic [1:0]  sel;
  logic [7:0]  exp_q[$];
  int          n_mismatch, comparisons, cyc, c, st, k;
  logic [12:0] acc_t[8] = '{`ACC_0, `ACC_1, `ACC_2, `ACC_3, `ACC_4, `ACC_5, `ACC_6, `ACC_7};
  logic [12:0] rej_t[8] = '{`REJ_0, `REJ_1, `REJ_2, `REJ_3, `REJ_4, `REJ_5, `REJ_6, `REJ_7};
  logic [12:0] cap_t[8] = '{`CAPLIM_12, `CAPLIM_52, `CAPLIM_83, `CAPLIM_130, `CAPLIM_400,
                            `CAPLIM_NONE, `CAPLIM_NONE, `CAPLIM_NONE};
  logic [7:0]  adr_t[5] = '{8'hed, 8'hf4, 8'hf5, 8'hf6, 8'hf7};
  logic [7:0]  rst_t[5] = '{8'h07, 8'hf0, 8'h00, 8'h33, 8'h33};
  dpll_ref_monitor_config dpll_ref_monitor_config_inst (.core_clk, .rst_n, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .offset_valid, .ref_offset, .loop_offset,
    .loop_in_range, .capture_range_code, .ref_failed, .ref_alarm, .ref_switch_req, .holdover_req);
  assign seen = sel == 2'h0 ? reg_rdata : sel == 2'h1 ? {ref_failed, ref_alarm} :
                sel == 2'h2 ? {ref_switch_req, holdover_req} :
                {3'h0, loop_in_range, reg_hit, capture_range_code};
  // ----------------------------------------
  // compare, close, watch
  // ----------------------------------------
  task check(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task end_of_test;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_mismatch++;
      end_of_test;
    end
    if (reg_rd) check(seen, exp_q.pop_front());
  end
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk); #1;
    reg_wr = 1; reg_addr = a; reg_wdata = d;
    @(posedge core_clk); #1;
    reg_wr = 0;
  endtask
  task chk(input logic [1:0] s, input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk); #1;
    reg_rd = 1; sel = s; reg_addr = a; exp_q.push_back(e);
    @(posedge core_clk); #1;
    reg_rd = 0;
  endtask
  initial begin
    rst_n = 0; reg_wr = 0; reg_rd = 0; offset_valid = 0; reg_addr = 0; reg_wdata = 0;
    ref_offset = 0; loop_offset = 0; sel = 0;
    void'($urandom(32'h389a));
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1;
    for (c = 0; c < 5; c++) chk(0, adr_t[c], rst_t[c]);
    wr(8'hee, 8'h5a);
    chk(0, 8'hee, 8'h00);
    chk(3, 8'hee, 8'h17);
    for (c = 0; c < 5; c++) begin
      rnd = $urandom;
      if (c == 0 && rnd[2] && (rnd[1] ^ rnd[0])) rnd[1:0] = 2'h3;
      wr(adr_t[c], rnd);
      chk(0, adr_t[c], rnd);
    end
    for (c = 0; c < 8; c++) begin
      w = c > 4 ? 3'h7 : 3'(c); // reserved codes never written
      wr(8'hed, {5'($urandom), w});
      loop_offset = cap_t[w];
      chk(3, 8'hed, {4'h1, 1'b1, w});
      loop_offset = cap_t[w] + 13'h1;
      chk(3, 8'hed, {3'h0, w == 3'h7, 1'b1, w});
    end
    rnd = $urandom;
    wr(8'hf5, rnd);
    for (c = 0; c < 8; c++) begin
      wr(8'hf7, {1'b0, 3'(c + 1), 1'b0, 3'(c)});
      wr(8'hf6, {1'b0, 3'(c + 3), 1'b0, 3'(c + 2)});
      for (st = 0; st < 5; st++) begin
        for (k = 0; k < 4; k++) begin
          w = 3'(c + k);
          ref_offset[k*13+:13] = st == 2 ? acc_t[w] : st == 1 ? acc_t[w] + 13'h1 :
                                 st == 3 ? rej_t[w] : rej_t[w] + 13'h1;
        end
        @(posedge core_clk); #1 offset_valid = 1;
        @(posedge core_clk); #1 offset_valid = 0;
        chk(1, 0, {{4{st != 2 && st != 3}}, {4{st != 2 && st != 3}} & rnd[3:0]});
      end
    end
    for (c = 0; c < 4; c++) begin
      wr(8'hf4, {3'h0, c[1], 3'h0, c[0]});
      chk(2, 0, {rnd[3:0] & {4{c[0]}}, rnd[3:0] & {4{c[1]}}});
    end
    end_of_test;
  end
endmodule
`default_nettype wire
